// ---- verilog/drive_control_status_word.sv ----
// Remote command word to sequencer inputs, and status word from sequencer outputs.
// Assumes one AHB-Lite master, sequencer and ramp flags synchronous to hclk.
// Notes on behaviour
// - Remote mode takes sequencing from command word
// - Bit 0 drives forward run only
// - Coast stop is bit 1 AND local
// - Fast stop is bit 2 AND local
// - Enable is bit 3 AND local enable
// - Bit 7 follows fault clear, rising resets
// - Status word, unsupported bits read zero
// - Status bit 0 is start permitted
// - Status bit 1 is stack energised
// - Status bit 2 is running
// - Status bit 3 is fault latched
// - Status bit 4 mirrors coast stop source
// - Status bit 5 mirrors fast stop source
// - Status bit 6 set in start inhibit
// - Sequencer state encoded zero to seven
// - Status bit 9 remote and network select
// - Status bit 10 when not ramping
// - Status bit 11 torque or current limit
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module drive_control_status_word (
  input  wire logic                        hclk,                // 200 MHz clock
  input  wire logic                        hresetn,             // Async reset, low
  input  wire logic                        hsel,                // Slave select
  input  wire logic [7:0]                  haddr,               // Byte address
  input  wire logic [1:0]                  htrans,              // Transfer type
  input  wire logic                        hwrite,              // Write strobe
  input  wire logic [2:0]                  hsize,               // Transfer size
  input  wire logic [31:0]                 hwdata,              // Write data
  input  wire logic                        hready,              // Bus ready in
  output logic      [31:0]                 hrdata,              // Read data
  output logic                             hreadyout,           // Slave ready
  output logic                             hresp,               // Always OKAY
  input  wire logic                        local_run_forward,   // Local run forward
  input  wire logic                        local_run_reverse,   // Local run reverse
  input  wire logic                        local_hold_release,  // Local hold release
  input  wire logic                        local_fault_clear,   // Local trip reset
  input  wire logic                        freewheel_halt_n,    // Local coast stop, low
  input  wire logic                        quick_halt_n,        // Local fast stop, low
  input  wire logic                        power_stage_enable,  // Local enable
  input  wire logic                        start_permitted,     // Sequencer output
  input  wire logic                        stack_energised,     // Sequencer output
  input  wire logic                        running,             // Sequencer output
  input  wire logic                        fault_latched,       // Sequencer output
  input  wire cmd_status_pkg::seq_state_t  seq_state,           // Sequencer state
  input  wire logic                        ramping,             // Reference ramp busy
  input  wire logic                        vector_mode,         // Vector control selected
  input  wire logic                        torque_limit,        // Speed loop in torque limit
  input  wire logic                        current_limit,       // Open loop current limit
  output logic                             run_forward,         // Sequencer input
  output logic                             run_reverse,         // Sequencer input
  output logic                             run_hold_release,    // Sequencer input
  output logic                             coast_stop_n,        // Sequencer input, low
  output logic                             fast_stop_n,         // Sequencer input, low
  output logic                             seq_enable,          // Sequencer input
  output logic                             remote_fault_clear,  // Sequencer input
  output logic                             fault_reset_pulse,   // Rising edge of trip reset
  output logic      [15:0]                 status_word          // Status word
);

  logic [15:0] command;
  logic [15:0] next_command;
  logic [1:0]  mode;
  logic [1:0]  next_mode;
  logic        ph_write;
  logic        next_ph_write;
  logic        next_ph_read;
  logic [7:0]  ph_addr;
  logic [7:0]  next_ph_addr;
  logic [31:0] next_hrdata;
  logic [15:0] next_status;
  logic        clear_prev;
  logic        next_clear_prev;
  logic        remote;
  logic        access;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign remote    = mode[cmd_status_pkg::mode_remote_bit];
  assign access    = hsel && hready && htrans == cmd_status_pkg::htrans_nonseq;

  // Address phase capture; writes land in the following data phase
  always_comb begin
    next_ph_write = access && hwrite && hsize == cmd_status_pkg::hsize_word;
    next_ph_read  = access && !hwrite;
    next_ph_addr  = access ? haddr : ph_addr;
    next_command  = command;
    next_mode     = mode;
    if (ph_write && ph_addr == cmd_status_pkg::cmd_offset) begin
      next_command = hwdata[15:0];
    end
    if (ph_write && ph_addr == cmd_status_pkg::mode_offset) begin
      next_mode = hwdata[1:0];
    end
  end

  // Reads are prepared one cycle ahead so hrdata comes from a flip-flop.
  // Command and mode reads use the next values, so a read right behind a write sees it;
  // the sequencer input view still lags such a write by one cycle.
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_ph_read) begin
      case (haddr)
        cmd_status_pkg::cmd_offset:    next_hrdata = {16'h0000, next_command};
        cmd_status_pkg::status_offset: next_hrdata = {16'h0000, next_status};
        cmd_status_pkg::mode_offset:   next_hrdata = {30'h0, next_mode};
        cmd_status_pkg::seq_in_offset: next_hrdata = {25'h0, remote_fault_clear, seq_enable,
                                                      fast_stop_n, coast_stop_n, run_hold_release,
                                                      run_reverse, run_forward};
        default:                       next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    if (remote) begin
      run_forward        = command[cmd_status_pkg::cmd_switch_on];
      run_reverse        = 1'b0;
      run_hold_release   = 1'b0;
      coast_stop_n       = command[cmd_status_pkg::cmd_not_coast] & freewheel_halt_n;
      fast_stop_n        = command[cmd_status_pkg::cmd_not_fast] & quick_halt_n;
      seq_enable         = command[cmd_status_pkg::cmd_enable_op] & power_stage_enable;
      remote_fault_clear = command[cmd_status_pkg::cmd_fault_reset];
    end else begin
      run_forward        = local_run_forward;
      run_reverse        = local_run_reverse;
      run_hold_release   = local_hold_release;
      coast_stop_n       = freewheel_halt_n;
      fast_stop_n        = quick_halt_n;
      seq_enable         = power_stage_enable;
      remote_fault_clear = local_fault_clear;
    end
  end

  assign next_clear_prev   = remote_fault_clear;
  assign fault_reset_pulse = remote_fault_clear & ~clear_prev;

  always_comb begin
    next_status = 16'h0000;
    next_status[cmd_status_pkg::st_ready_switch_on] = start_permitted;
    next_status[cmd_status_pkg::st_switched_on]     = stack_energised;
    next_status[cmd_status_pkg::st_op_enabled]      = running;
    next_status[cmd_status_pkg::st_fault]           = fault_latched;
    next_status[cmd_status_pkg::st_not_coast]       = remote ? command[cmd_status_pkg::cmd_not_coast]
                                                             : freewheel_halt_n;
    next_status[cmd_status_pkg::st_not_fast]        = remote ? command[cmd_status_pkg::cmd_not_fast]
                                                             : quick_halt_n;
    next_status[cmd_status_pkg::st_inhibit]         = seq_state == cmd_status_pkg::seq_start_inhibit;
    next_status[cmd_status_pkg::st_remote]          = remote & mode[cmd_status_pkg::mode_netsel_bit];
    next_status[cmd_status_pkg::st_setpoint]        = ~ramping;
    next_status[cmd_status_pkg::st_limit]           = vector_mode ? torque_limit : current_limit;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      command  <= cmd_status_pkg::cmd_reset;
      mode     <= cmd_status_pkg::mode_reset;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end else begin
      command  <= next_command;
      mode     <= next_mode;
      ph_write <= next_ph_write;
      ph_addr  <= next_ph_addr;
    end
  end

  // Read data stands for the data phase only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_word <= 16'h0000;
    end else begin
      status_word <= next_status;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clear_prev <= 1'b0;
    end else begin
      clear_prev <= next_clear_prev;
    end
  end

endmodule // drive_control_status_word

// ---- verilog/cmd_status_pkg.sv ----
// Register map, command and status field layout for the remote sequencing block.
// Assumes an AHB-Lite master with 32-bit single word transfers.
package cmd_status_pkg;
  localparam logic [7:0]  cmd_offset         = 8'h00;
  localparam logic [7:0]  status_offset      = 8'h04;
  localparam logic [7:0]  mode_offset        = 8'h08;
  localparam logic [7:0]  seq_in_offset      = 8'h0c;
  localparam logic [15:0] cmd_reset          = 16'h0000;
  localparam logic [1:0]  mode_reset         = 2'h0;
  localparam logic [1:0]  htrans_nonseq      = 2'h2;
  localparam logic [2:0]  hsize_word         = 3'h2;
  localparam int          cmd_switch_on      = 0;
  localparam int          cmd_not_coast      = 1;
  localparam int          cmd_not_fast       = 2;
  localparam int          cmd_enable_op      = 3;
  localparam int          cmd_fault_reset    = 7;
  localparam int          st_ready_switch_on = 0;
  localparam int          st_switched_on     = 1;
  localparam int          st_op_enabled      = 2;
  localparam int          st_fault           = 3;
  localparam int          st_not_coast       = 4;
  localparam int          st_not_fast        = 5;
  localparam int          st_inhibit         = 6;
  localparam int          st_remote          = 9;
  localparam int          st_setpoint        = 10;
  localparam int          st_limit           = 11;
  localparam int          mode_remote_bit    = 0;
  localparam int          mode_netsel_bit    = 1;
  // Sequencer state encoding
  typedef enum logic [2:0] {
    seq_start_inhibit  = 3'h0,
    seq_start_permit   = 3'h1,
    seq_switched_on    = 3'h2,
    seq_ready          = 3'h3,
    seq_enabled        = 3'h4,
    seq_fast_stop      = 3'h5,
    seq_trip_active    = 3'h6,
    seq_tripped        = 3'h7
  } seq_state_t;
endpackage

// ---- tb/drive_control_status_word_props.sv ----
// Checker for the command and status mapping of the remote sequencing block.
// Assumes the ports of drive_control_status_word; bound at the foot.
`timescale 1ns/1ps
module drive_control_status_word_props (
  input wire logic hclk, hresetn, freewheel_halt_n, quick_halt_n, power_stage_enable, // Clock, reset, local
  input wire logic start_permitted, stack_energised, running, fault_latched,          // Sequencer outputs
  input wire cmd_status_pkg::seq_state_t seq_state,                                  // Sequencer state
  input wire logic ramping, vector_mode, torque_limit, current_limit,                // Ramp and limits
  input wire logic run_forward, coast_stop_n, fast_stop_n, seq_enable,               // Sequencer inputs
  input wire logic remote_fault_clear, fault_reset_pulse,                            // Trip reset
  input wire logic [15:0] status_word                                                // Status word
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_status_seq_bits: assert property (
    $past(hresetn) |-> status_word[3:0] == $past({fault_latched, running, stack_energised, start_permitted}))
    else $error("status sequencer bits wrong");
  a_status_zero_bits: assert property (status_word[15:12] == 4'h0 && status_word[8:7] == 2'h0)
    else $error("unsupported status bits set");
  a_status_inhibit: assert property (
    $past(hresetn) |-> status_word[6] == ($past(seq_state) == cmd_status_pkg::seq_start_inhibit))
    else $error("inhibit status bit wrong");
  a_status_setpoint: assert property ($past(hresetn) |-> status_word[10] == !$past(ramping))
    else $error("setpoint status bit wrong");
  a_status_limit: assert property (
    $past(hresetn) |-> status_word[11] == $past(vector_mode ? torque_limit : current_limit))
    else $error("limit status bit wrong");
  a_coast_and: assert property (coast_stop_n |-> freewheel_halt_n)
    else $error("coast stop ignores local input");
  a_fast_and: assert property (fast_stop_n |-> quick_halt_n)
    else $error("fast stop ignores local input");
  a_enable_and: assert property (seq_enable |-> power_stage_enable)
    else $error("enable ignores local input");
  a_clear_edge: assert property (
    $past(hresetn) |-> fault_reset_pulse == (remote_fault_clear && !$past(remote_fault_clear)))
    else $error("trip reset pulse not on rising edge");
  c_run: cover property (run_forward);
  c_pulse: cover property (fault_reset_pulse);
  c_remote: cover property (status_word[9]);
endmodule // drive_control_status_word_props

bind drive_control_status_word drive_control_status_word_props u_props (
  .hclk, .hresetn, .freewheel_halt_n, .quick_halt_n, .power_stage_enable, .start_permitted, .stack_energised,
  .running, .fault_latched, .seq_state, .ramping, .vector_mode, .torque_limit, .current_limit, .run_forward,
  .coast_stop_n, .fast_stop_n, .seq_enable, .remote_fault_clear, .fault_reset_pulse, .status_word);

// ---- tb/plc_master.sv ----
// Remote master model: single-word AHB-Lite transfers and command words.
// Assumes one slave whose hreadyout is the bus ready.
`timescale 1ns/1ps
module plc_master (
  input  wire logic        hclk,      // Bus clock
  input  wire logic        hreadyout, // Slave ready
  input  wire logic [31:0] hrdata,    // Read data
  output logic             hsel,      // Slave select
  output logic [7:0]       haddr,     // Byte address
  output logic [1:0]       htrans,    // Transfer type
  output logic             hwrite,    // Write strobe
  output logic [2:0]       hsize,     // Always a word
  output logic [31:0]      hwdata     // Write data
);
  initial begin
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = cmd_status_pkg::hsize_word;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= cmd_status_pkg::htrans_nonseq;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic cmd(input logic [4:0] f);
    logic [31:0] q;
    xfer(1'b1, cmd_status_pkg::cmd_offset, {16'h0, 16'h0470 | {8'h00, f[4], 3'h0, f[3:0]}}, q);
  endtask
endmodule // plc_master

// ---- tb/drive_control_status_word_tb.sv ----
// Self-checking bench for drive_control_status_word with the remote master model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module drive_control_status_word_tb;
  typedef struct packed {logic [3:0] sq; logic [2:0] st; logic [3:0] rl; logic [15:0] ex;} row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic local_run_forward, local_run_reverse, local_hold_release, local_fault_clear;
  logic freewheel_halt_n, quick_halt_n, power_stage_enable, ramping, vector_mode, torque_limit, current_limit;
  logic start_permitted, stack_energised, running, fault_latched;
  cmd_status_pkg::seq_state_t seq_state;
  logic run_forward, run_reverse, run_hold_release, coast_stop_n, fast_stop_n, seq_enable;
  logic remote_fault_clear, fault_reset_pulse;
  logic [15:0] status_word;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  row_t rows [4] = '{'{4'h0, 3'h0, 4'h8, 16'h0070}, '{4'h1, 3'h1, 4'h6, 16'h0c31},
                     '{4'h6, 3'h4, 4'h5, 16'h0436}, '{4'h8, 3'h7, 4'h9, 16'h0838}};
  assign hready = hreadyout;
  drive_control_status_word u_drive_control_status_word (.*);
  plc_master u_plc_master (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Registered status needs one rising edge after any input change
  task automatic settle;
    repeat (2) @(negedge hclk);
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    hresetn = 1'b0;
    {local_run_forward, local_run_reverse, local_hold_release, local_fault_clear} = 4'h8;
    {freewheel_halt_n, quick_halt_n, power_stage_enable} = 3'h7;
    {start_permitted, stack_energised, running, fault_latched} = 4'h0;
    {ramping, vector_mode, torque_limit, current_limit} = 4'h0;
    seq_state = cmd_status_pkg::seq_start_inhibit;
    repeat (2) @(posedge hclk);
    chk({16'h0, status_word}, 32'h0);
    hresetn <= 1'b1;
    u_plc_master.xfer(1'b0, cmd_status_pkg::cmd_offset, 32'h0, rd);
    chk(rd, {16'h0, cmd_status_pkg::cmd_reset});
    chk({31'h0, run_forward}, 32'h1);
    foreach (rows[i]) begin
      @(posedge hclk);
      {fault_latched, running, stack_energised, start_permitted} <= rows[i].sq;
      seq_state <= cmd_status_pkg::seq_state_t'(rows[i].st);
      {ramping, vector_mode, torque_limit, current_limit} <= rows[i].rl;
      settle();
      chk({16'h0, status_word}, {16'h0, rows[i].ex});
      u_plc_master.xfer(1'b0, cmd_status_pkg::status_offset, 32'h0, rd);
      chk(rd, {16'h0, rows[i].ex});
    end
    u_plc_master.xfer(1'b1, cmd_status_pkg::mode_offset, 32'h3, rd);
    u_plc_master.cmd(5'h0f);
    settle();
    chk({26'h0, run_forward, run_reverse, run_hold_release, coast_stop_n, fast_stop_n, seq_enable}, 32'h27);
    chk({29'h0, status_word[9], status_word[5:4]}, 32'h7);
    @(posedge hclk);
    {freewheel_halt_n, quick_halt_n} <= 2'h0;
    settle();
    chk({28'h0, coast_stop_n, fast_stop_n, status_word[5:4]}, 32'h3);
    @(posedge hclk);
    {freewheel_halt_n, quick_halt_n, power_stage_enable} <= 3'h6;
    u_plc_master.cmd(5'h09);
    settle();
    chk({27'h0, coast_stop_n, fast_stop_n, seq_enable, status_word[5:4]}, 32'h0);
    u_plc_master.cmd(5'h0e);
    settle();
    chk({31'h0, run_forward}, 32'h0);
    u_plc_master.xfer(1'b0, cmd_status_pkg::cmd_offset, 32'h0, rd);
    chk(rd, 32'h047e);
    u_plc_master.cmd(5'h1e);
    @(negedge hclk);
    chk({30'h0, remote_fault_clear, fault_reset_pulse}, 32'h3);
    @(negedge hclk);
    chk({30'h0, remote_fault_clear, fault_reset_pulse}, 32'h2);
    u_plc_master.xfer(1'b1, cmd_status_pkg::mode_offset, 32'h1, rd);
    settle();
    chk({31'h0, status_word[9]}, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    // Mid-run reset must drop back to local mode with a cleared command
    @(posedge hclk);
    hresetn <= 1'b0;
    {freewheel_halt_n, quick_halt_n} <= 2'h1;
    settle();
    chk({16'h0, status_word}, 32'h0);
    chk({26'h0, seq_enable, fast_stop_n, coast_stop_n, run_hold_release, run_reverse, run_forward}, 32'h11);
    @(posedge hclk);
    hresetn <= 1'b1;
    u_plc_master.xfer(1'b0, cmd_status_pkg::seq_in_offset, 32'h0, rd);
    chk(rd, 32'h11);
    u_plc_master.xfer(1'b0, cmd_status_pkg::mode_offset, 32'h0, rd);
    chk(rd, {30'h0, cmd_status_pkg::mode_reset});
    u_plc_master.xfer(1'b0, cmd_status_pkg::cmd_offset, 32'h0, rd);
    chk(rd, {16'h0, cmd_status_pkg::cmd_reset});
    chk({16'h0, status_word}, 32'h0828);
    stop_test();
  end
endmodule // drive_control_status_word_tb
